// ### rtl/flash_cfg_bank.v
`timescale 1ns/1ps
`include "flash_cfg_regs.vh"
module flash_cfg_bank (
  // clock and reset
  input  wire                   clk,
  input  wire                   nrst,
  // serial link pins
  input  wire                   sclk,
  input  wire                   cs_n,
  input  wire [3:0]             dq_i,
  output wire [3:0]             dq_o,
  output wire [3:0]             dq_oe,
  // strap and status from the rest of the device
  input  wire                   nv_seg_default,
  input  wire                   four_byte_mode,
  input  wire                   busy_program,
  input  wire                   busy_erase,
  input  wire                   busy_wr_status,
  input  wire                   busy_wr_nvcfg,
  // array operation address path
  input  wire                   op_start,
  input  wire                   op_bulk,
  input  wire [31:0]            op_addr,
  input  wire                   rd_next,
  output reg  [`ARRAY_AW-1:0]   array_addr,
  output reg                    erase_all,
  // configuration outputs
  output reg  [1:0]             protocol,
  output reg                    hold_reset_en,
  output reg                    accel_en,
  output reg  [2:0]             drive_strength,
  output reg                    clr_error_flags
);
  localparam ST_CMD  = 2'h0;
  localparam ST_WR   = 2'h1;
  localparam ST_RD   = 2'h2;
  localparam ST_SKIP = 2'h3;

  // link inputs cross with two flops each; first stage feeds only the second
  reg  [5:0] sync1_q;
  reg  [5:0] sync2_q;
  reg        sclk_prev_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // idle levels: deselected, serial clock low, so no false edge follows reset
      sync1_q     <= 6'h20;
      sync2_q     <= 6'h20;
      sclk_prev_q <= 1'b0;
    end else begin
      sync1_q     <= {cs_n, sclk, dq_i};
      sync2_q     <= sync1_q;
      sclk_prev_q <= sync2_q[4];
    end
  end
  wire       cs_act = ~sync2_q[5];
  wire       s_rise = sync2_q[4] & ~sclk_prev_q;
  wire       s_fall = ~sync2_q[4] & sclk_prev_q;
  wire [3:0] dq_s   = sync2_q[3:0];

  reg        seg_q;
  reg        strap_done_q;
  reg  [7:0] ev_q;
  reg  [1:0] st_q;
  reg  [7:0] cmd_q;
  reg  [7:0] sh_q;
  reg  [3:0] cnt_q;
  reg  [7:0] out_q;
  reg  [3:0] ocnt_q;
  reg  [3:0] dqo_q;
  reg        ev_wr_q;
  reg        cs_prev_q;
  // lanes stay driven to the end of the read frame, not just while bits remain
  reg        oe_on_q;

  // bits moved per clock follow the protocol in force
  reg  [3:0] step;
  reg  [7:0] sh_d;
  always @* begin
    step = 4'h1;
    sh_d = {sh_q[6:0], dq_s[0]};
    case (protocol)
      `PROTO_DUAL: begin
        step = 4'h2;
        sh_d = {sh_q[5:0], dq_s[1:0]};
      end
      `PROTO_QUAD: begin
        step = 4'h4;
        sh_d = {sh_q[3:0], dq_s};
      end
      default: begin
        step = 4'h1;
        sh_d = {sh_q[6:0], dq_s[0]};
      end
    endcase
  end
  wire byte_done = (cnt_q + step) == 4'h8;

  // read data for the command held in cmd_q
  // any background cycle counts as busy for the ready bit
  wire       busy_any = busy_program | busy_erase | busy_wr_status | busy_wr_nvcfg;
  wire [7:0] flags    = {~busy_any, 7'h00};
  reg  [7:0] rd_data;
  always @* begin
    case (cmd_q)
      `CMD_RD_SEGMENT: rd_data = {7'h00, seg_q};
      `CMD_RD_EVSETUP: rd_data = ev_q & `EV_IMPL_MSK;
      `CMD_RD_FLAGS:   rd_data = flags;
      default:         rd_data = 8'h00;
    endcase
  end

  // output shifter next state; a reload takes a fresh copy of the read data,
  // so a long read repeats the byte and the busy bit is seen fresh each time
  wire       reload = (ocnt_q == 4'h0);
  wire [7:0] src    = reload ? rd_data : out_q;
  reg  [7:0] out_d;
  reg  [3:0] dqo_d;
  reg  [3:0] ocnt_d;
  always @* begin
    out_d  = {src[6:0], 1'b0};
    dqo_d  = {2'b00, src[7], 1'b0};
    ocnt_d = reload ? 4'h7 : ocnt_q - 4'h1;
    case (protocol)
      `PROTO_DUAL: begin
        out_d  = {src[5:0], 2'b00};
        dqo_d  = {2'b00, src[7:6]};
        ocnt_d = reload ? 4'h6 : ocnt_q - 4'h2;
      end
      `PROTO_QUAD: begin
        out_d  = {src[3:0], 4'h0};
        dqo_d  = src[7:4];
        ocnt_d = reload ? 4'h4 : ocnt_q - 4'h4;
      end
      default: begin
        out_d  = {src[6:0], 1'b0};
        dqo_d  = {2'b00, src[7], 1'b0};
        ocnt_d = reload ? 4'h7 : ocnt_q - 4'h1;
      end
    endcase
  end

  // command engine on detected serial clock edges
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q            <= ST_CMD;
      cmd_q           <= 8'h00;
      sh_q            <= 8'h00;
      cnt_q           <= 4'h0;
      out_q           <= 8'h00;
      ocnt_q          <= 4'h0;
      dqo_q           <= 4'h0;
      seg_q           <= 1'b0;
      strap_done_q    <= 1'b0;
      ev_q            <= `EV_RESET;
      ev_wr_q         <= 1'b0;
      cs_prev_q       <= 1'b0;
      oe_on_q         <= 1'b0;
      clr_error_flags <= 1'b0;
    end else begin
      cs_prev_q       <= cs_act;
      clr_error_flags <= 1'b0;
      // strap is caught by a clocked load after reset release
      if (!strap_done_q) begin
        strap_done_q <= 1'b1;
        seg_q        <= nv_seg_default;
      end
      if (!cs_act) begin
        st_q   <= ST_CMD;
        cnt_q  <= 4'h0;
        ocnt_q <= 4'h0;
        ev_wr_q <= 1'b0;
        oe_on_q <= 1'b0;
      end else if (s_rise) begin
        case (st_q)
          ST_CMD: begin
            sh_q  <= sh_d;
            cnt_q <= byte_done ? 4'h0 : cnt_q + step;
            if (byte_done) begin
              cmd_q <= sh_d;
              case (sh_d)
                `CMD_WR_SEGMENT, `CMD_WR_EVSETUP: st_q <= ST_WR;
                `CMD_RD_SEGMENT, `CMD_RD_EVSETUP, `CMD_RD_FLAGS: st_q <= ST_RD;
                `CMD_CLR_FLAGS: begin
                  clr_error_flags <= 1'b1;
                  st_q            <= ST_SKIP;
                end
                default: st_q <= ST_SKIP;
              endcase
            end
          end
          ST_WR: begin
            sh_q  <= sh_d;
            cnt_q <= byte_done ? 4'h0 : cnt_q + step;
            if (byte_done) begin
              st_q <= ST_SKIP;
              if (cmd_q == `CMD_WR_SEGMENT)
                seg_q <= sh_d[`SEG_BIT];
              else begin
                ev_q    <= sh_d & `EV_IMPL_MSK;
                ev_wr_q <= 1'b1;
              end
            end
          end
          default: st_q <= st_q;
        endcase
      end
      // output bits change on the falling serial edge for the host to sample
      if (cs_act && s_fall && st_q == ST_RD) begin
        oe_on_q <= 1'b1;
        dqo_q   <= dqo_d;
        out_q   <= out_d;
        ocnt_q  <= ocnt_d;
      end
    end
  end

  // setup fields go live only when its write command frame closes
  wire ev_commit = cs_prev_q & ~cs_act & ev_wr_q;

  // quad outranks dual when both enables are low
  reg  [1:0] proto_d;
  always @* begin
    case ({ev_q[`EV_QUAD_BIT], ev_q[`EV_DUAL_BIT]})
      2'b00:   proto_d = `PROTO_QUAD;
      2'b01:   proto_d = `PROTO_QUAD;
      2'b10:   proto_d = `PROTO_DUAL;
      default: proto_d = `PROTO_EXT;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      protocol       <= `PROTO_EXT;
      hold_reset_en  <= 1'b1;
      accel_en       <= 1'b0;
      drive_strength <= 3'h7;
    end else if (ev_commit) begin
      protocol       <= proto_d;
      hold_reset_en  <= ev_q[`EV_HOLD_BIT];
      accel_en       <= ~ev_q[`EV_ACCEL_BIT];
      drive_strength <= ev_q[`EV_DRIVE_MSB:0];
    end
  end

  // a read must never drive while the command is still arriving
  reg [3:0] oe_mask;
  always @* begin
    case (protocol)
      `PROTO_DUAL: oe_mask = 4'h3;
      `PROTO_QUAD: oe_mask = 4'hF;
      default:     oe_mask = 4'h2;
    endcase
  end
  assign dq_o  = dqo_q;
  assign dq_oe = (cs_act && st_q == ST_RD && oe_on_q) ? oe_mask : 4'h0;

  // array address path; segment bit is only read here, never written
  // next address: a fresh operation loads, a read step advances and wraps
  reg  [`ARRAY_AW-1:0] addr_d;
  reg                  erase_d;
  always @* begin
    addr_d  = array_addr;
    erase_d = erase_all;
    if (op_start) begin
      erase_d = op_bulk;
      if (four_byte_mode)
        addr_d = op_addr[`ARRAY_AW-1:0];
      else
        addr_d = {seg_q, op_addr[`HALF_AW-1:0]};
    end else if (rd_next) begin
      // the 25-bit sum drops its carry, so the last address 1FFFFFF wraps to zero
      addr_d = array_addr + {{(`ARRAY_AW-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      array_addr <= {`ARRAY_AW{1'b0}};
      erase_all  <= 1'b0;
    end else begin
      array_addr <= addr_d;
      erase_all  <= erase_d;
    end
  end
endmodule

// ### rtl/flash_cfg_regs.vh
`ifndef FLASH_CFG_REGS_VH
`define FLASH_CFG_REGS_VH
// command codes of the register commands
`define CMD_WR_SEGMENT   8'hC5
`define CMD_RD_SEGMENT   8'hC8
`define CMD_WR_EVSETUP   8'h61
`define CMD_RD_EVSETUP   8'h65
`define CMD_RD_FLAGS     8'h70
`define CMD_CLR_FLAGS    8'h50
// segment register layout
`define SEG_BIT          0
`define SEG_RESERVED_MSK 8'h01
// enhanced volatile setup layout
`define EV_QUAD_BIT      7
`define EV_DUAL_BIT      6
`define EV_HOLD_BIT      4
`define EV_ACCEL_BIT     3
`define EV_DRIVE_MSB     2
`define EV_IMPL_MSK      8'hDF
`define EV_RESET         8'hDF
// flag status layout
`define FLAG_READY_BIT   7
// bus protocols
`define PROTO_EXT        2'h0
`define PROTO_DUAL       2'h1
`define PROTO_QUAD       2'h2
// array addressing: 256Mb is 25 byte-address bits
`define ARRAY_AW         25
`define HALF_AW          24
`endif

// ### test/flash_cfg_bank_assertions.sv
`timescale 1ns/1ps
module flash_cfg_bank_chk (
  // clock and reset
  input wire        clk,
  input wire        nrst,
  // watched ports
  input wire        cs_n,
  input wire [3:0]  dq_oe,
  input wire        four_byte_mode,
  input wire        op_start,
  input wire        op_bulk,
  input wire [31:0] op_addr,
  input wire        rd_next,
  input wire [24:0] array_addr,
  input wire        erase_all,
  input wire [1:0]  protocol,
  input wire        hold_reset_en,
  input wire        accel_en,
  input wire [2:0]  drive_strength,
  input wire        clr_error_flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_addr_three: assert property (op_start && !four_byte_mode |=> array_addr[23:0] == $past(op_addr[23:0]))
    else $error("low address bytes lost");
  chk_addr_four: assert property (op_start && four_byte_mode |=> array_addr == $past(op_addr[24:0]))
    else $error("4-byte address not taken whole");
  chk_addr_wrap: assert property (rd_next && !op_start |=> array_addr == $past(array_addr) + 25'h1)
    else $error("read address did not advance");
  chk_addr_hold: assert property (!op_start && !rd_next |=> $stable(array_addr))
    else $error("address moved without cause");
  chk_bulk_flag: assert property (op_start |=> erase_all == $past(op_bulk))
    else $error("bulk flag wrong");
  chk_proto_frame: assert property (!$stable(protocol) |-> cs_n)
    else $error("protocol changed inside a frame");
  chk_cfg_frame: assert property (!$stable({hold_reset_en, accel_en, drive_strength}) |-> cs_n)
    else $error("setup outputs changed inside a frame");
  chk_proto_code: assert property (protocol != 2'h3)
    else $error("bad protocol code");
  chk_lane_map: assert property (!cs_n && dq_oe != 4'h0 |-> dq_oe == (protocol == 2'h2 ? 4'hF : protocol == 2'h1 ? 4'h3 : 4'h2))
    else $error("lane enables disagree with protocol");
  chk_oe_idle: assert property (cs_n [*8] |-> dq_oe == 4'h0)
    else $error("lanes driven while deselected");
  chk_clr_pulse: assert property (clr_error_flags |=> !clr_error_flags)
    else $error("clear pulse too long");
  cover property (protocol == 2'h2);
  cover property (clr_error_flags);
  cover property (op_start && four_byte_mode);
endmodule
bind flash_cfg_bank flash_cfg_bank_chk flash_cfg_bank_chk_i (.*);

// ### test/flash_cfg_bank_bench.sv
`timescale 1ns/1ps
`include "flash_cfg_regs.vh"
module flash_cfg_bank_bench;
  logic        clk, nrst, sclk, cs_n, nv_seg_default, four_byte_mode, op_start, op_bulk, rd_next;
  logic [3:0]  busy, dq_i, dq_o, dq_oe;
  logic [31:0] op_addr;
  logic [24:0] array_addr;
  logic        erase_all, hold_reset_en, accel_en, clr_error_flags;
  logic [1:0]  protocol, pr;
  logic [2:0]  drive_strength;
  logic [7:0]  rd, v;
  int          bad_count, checked, clr_seen, c;
  flash_cfg_bank flash_cfg_bank_i (.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe(dq_oe), .nv_seg_default(nv_seg_default), .four_byte_mode(four_byte_mode),
    .busy_program(busy[0]), .busy_erase(busy[1]), .busy_wr_status(busy[2]), .busy_wr_nvcfg(busy[3]),
    .op_start(op_start), .op_bulk(op_bulk), .op_addr(op_addr), .rd_next(rd_next), .array_addr(array_addr),
    .erase_all(erase_all), .protocol(protocol), .hold_reset_en(hold_reset_en), .accel_en(accel_en),
    .drive_strength(drive_strength), .clr_error_flags(clr_error_flags));
  spi_host_model spi_host_model_i (.sclk(sclk), .cs_n(cs_n), .dq_i(dq_i), .dq_o(dq_o));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (clr_error_flags) clr_seen++;
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one pulse on op_start or rd_next; result is settled one edge later
  task automatic op(input logic [31:0] a, input logic b, f, r);
    @(posedge clk) #1;
    op_addr = a;
    op_bulk = b;
    four_byte_mode = f;
    op_start = !r;
    rd_next = r;
    @(posedge clk) #1;
    op_start = 1'b0;
    rd_next = 1'b0;
  endtask
  task automatic end_of_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #400000 bad_count++;
    end_of_test;
  end
  initial begin
    {nrst, four_byte_mode, op_start, op_bulk, rd_next, busy, op_addr} = '0;
    nv_seg_default = 1'b1;
    repeat (20) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (8) @(posedge clk);
    spi_host_model_i.frame(2'h0, `CMD_RD_EVSETUP, 8'h00, 16, rd);
    chk("setup reset", `EV_RESET, rd);
    chk("protocol", 2'h0, protocol);
    chk("hold", 1'b1, hold_reset_en);
    chk("accel", 1'b0, accel_en);
    spi_host_model_i.frame(2'h0, `CMD_RD_SEGMENT, 8'h00, 16, rd);
    chk("segment power-up", 8'h01, rd);
    spi_host_model_i.frame(2'h0, `CMD_WR_SEGMENT, 8'hFE, 16, rd);
    spi_host_model_i.frame(2'h0, `CMD_RD_SEGMENT, 8'h00, 16, rd);
    chk("segment reserved", 8'h00, rd);
    op(32'h00FFFFFF, 1'b0, 1'b0, 1'b0);
    chk("lower half", 25'h0FFFFFF, array_addr);
    spi_host_model_i.frame(2'h0, `CMD_WR_SEGMENT, 8'hFF, 16, rd);
    op(32'h00FFFFFF, 1'b1, 1'b0, 1'b0);
    chk("upper half", 25'h1FFFFFF, array_addr);
    chk("bulk", 1'b1, erase_all);
    op(32'h0, 1'b0, 1'b0, 1'b1);
    chk("read wrap", 25'h0, array_addr);
    spi_host_model_i.frame(2'h0, `CMD_RD_SEGMENT, 8'h00, 16, rd);
    chk("segment kept", 8'h01, rd);
    op(32'h00000005, 1'b0, 1'b1, 1'b0);
    chk("four byte", 25'h0000005, array_addr);
    $display("test address done");
    for (int i = 0; i < 5; i++) begin
      busy = (i < 4) ? 4'h1 << i : 4'h0;
      spi_host_model_i.frame(2'h0, `CMD_RD_FLAGS, 8'h00, 16, rd);
      chk("flag ready", (i < 4) ? 8'h00 : 8'h80, rd);
    end
    c = clr_seen;
    spi_host_model_i.frame(2'h0, `CMD_CLR_FLAGS, 8'h00, 8, rd);
    chk("clear pulse", c + 1, clr_seen);
    $display("test flags done");
    pr = 2'h0;
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 8'h37 : (k == 1) ? 8'hBE : 8'hC9;
      spi_host_model_i.frame(pr, `CMD_WR_EVSETUP, v, 16, rd);
      pr = v[7] ? (v[6] ? 2'h0 : 2'h1) : 2'h2;
      chk("protocol", pr, protocol);
      chk("accel", !v[3], accel_en);
      chk("hold", v[4], hold_reset_en);
      chk("drive", v[2:0], drive_strength);
      spi_host_model_i.frame(pr, `CMD_RD_EVSETUP, 8'h00, 16, rd);
      chk("setup read", v & 8'hDF, rd);
    end
    $display("test setup done");
    end_of_test;
  end
endmodule

// ### test/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  // link pins
  output logic       sclk,
  output logic       cs_n,
  output logic [3:0] dq_i,
  input  wire  [3:0] dq_o
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dq_i = 4'h0;
  end
  // nb bits per frame; clock stands low between frames, idle data inverted
  task automatic frame(input logic [1:0] pr, input logic [7:0] cmd, wd, input int nb, output logic [7:0] rd);
    logic [15:0] sh;
    int          n;
    n = (pr == 2'h2) ? 4 : (pr == 2'h1) ? 2 : 1;
    sh = {cmd, wd};
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < nb; i += n) begin
      #32 sclk = 1'b0;
      dq_i = sh[15:12] >> (4 - n);
      sh = sh << n;
      #32 sclk = 1'b1;
      if (i >= 8) rd = (rd << n) | ((n == 1) ? {3'h0, dq_o[1]} : dq_o & ((4'h1 << n) - 4'h1));
    end
    #32 sclk = 1'b0;
    #32 cs_n = 1'b1;
    dq_i = ~dq_i;
    #64;
  endtask
endmodule
